/* File: src/mpd_port.sv */
// Data, strobe, read-return and calibration side of the memory PHY port
`timescale 1ns/1ps
`default_nettype none
module mpd_port (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_b_i,
	// Write side from controller, strobe window and write valid one bit per slot
	input wire logic [mpd_pkg::RATE-1:0] strobe_window_i,
	input wire logic [mpd_pkg::RATE-1:0] wdata_valid_i,
	input wire logic [mpd_pkg::DQ_WIDTH-1:0] wdata_i,
	input wire logic [mpd_pkg::MASK_BUS_WIDTH-1:0] write_mask_or_inversion_i,
	input wire logic [mpd_pkg::MASK_BUS_WIDTH-1:0] byte_mask_b_i,
	input wire logic [mpd_pkg::WDQS_GROUPS*2-1:0] dinv_i,
	// Read side
	input wire logic [mpd_pkg::RATE-1:0] rdata_en_full_i,
	output logic [mpd_pkg::DQ_WIDTH-1:0] rdata_o,
	output logic [mpd_pkg::RATE-1:0] rdata_valid_o,
	// Calibration status
	input wire logic cal_req_i,
	input wire logic cal_result_ok_i,
	output logic cal_success_o,
	output logic cal_fail_o,
	output logic [mpd_pkg::LAT_WIDTH-1:0] wlat_o,
	output logic [mpd_pkg::LAT_WIDTH-1:0] rlat_o,
	// Tracking handshakes
	input wire logic tracking_enable_i,
	input wire logic [mpd_pkg::TRK_WIDTH-1:0] ctl_refresh_done_i,
	input wire logic [mpd_pkg::TRK_WIDTH-1:0] ctl_long_idle_i,
	output logic [mpd_pkg::TRK_WIDTH-1:0] seq_busy_o,
	// Memory pins, slot-parallel, earliest slot low
	output logic [mpd_pkg::DQ_WIDTH-1:0] mem_dq_o,
	output logic [mpd_pkg::RATE-1:0] mem_dq_oe_o,
	input wire logic [mpd_pkg::DQ_WIDTH-1:0] mem_dq_i,
	output logic [mpd_pkg::MASK_BUS_WIDTH-1:0] memory_mask_pin_o,
	output logic [mpd_pkg::RATE-1:0] memory_mask_pin_oe_o,
	output logic [mpd_pkg::MASK_BUS_WIDTH-1:0] mem_bws_b_o,
	output logic [mpd_pkg::WDQS_GROUPS*2-1:0] mem_dinv_o,
	output logic [2*mpd_pkg::RATE-1:0] mem_dqs_o,
	output logic [2*mpd_pkg::RATE-1:0] mem_dqs_c_o,
	output logic [mpd_pkg::RATE-1:0] mem_dqs_oe_o
);
	localparam int unsigned R = mpd_pkg::RATE;

	mpd_pkg::mpd_state_t state_reg, state_next;
	logic [7:0] cnt_reg, cnt_next;
	logic ok_reg, ok_next;
	logic fail_reg, fail_next;
	logic [5:0] wlat_reg, wlat_next;
	logic [5:0] rlat_reg, rlat_next;
	logic [3:0] busy_reg, busy_next;
	logic [2*R-1:0] dqs_reg, dqs_next;
	logic [2*R-1:0] dqsc_reg, dqsc_next;
	logic [R-1:0] dqs_oe_reg, dqs_oe_next;
	logic [mpd_pkg::MASK_BUS_WIDTH-1:0] bws_reg, bws_next;
	logic [mpd_pkg::WDQS_GROUPS*2-1:0] dinv_reg, dinv_next;
	logic [mpd_pkg::DQ_WIDTH-1:0] rdata_reg, rdata_next;
	logic [R-1:0] rvalid_reg, rvalid_next;
	logic trk_req;

	// Each enabled slot toggles the strobe once per memory clock: high then low
	function automatic logic [2*R-1:0] strobe_wave(input logic [R-1:0] en,
		input logic inv);
		logic [2*R-1:0] w;
		w = '0;
		for (int i = 0; i < R; i++)
		begin
			w[2*i] = en[i] ^ inv;
			w[2*i+1] = ~en[i] ^ inv;
		end
		return w;
	endfunction : strobe_wave

	// Data and mask share one enable per slot
	mpd_lane #(.W(mpd_pkg::DQ_PINS)) u_dq (
		.clock_i(clock_i),
		.rst_b_i(rst_b_i),
		.word_i(wdata_i),
		.en_i(wdata_valid_i),
		.pin_o(mem_dq_o),
		.oe_o(mem_dq_oe_o)
	);

	mpd_lane #(.W(mpd_pkg::MASK_PINS)) u_dm (
		.clock_i(clock_i),
		.rst_b_i(rst_b_i),
		.word_i(write_mask_or_inversion_i),
		.en_i(wdata_valid_i),
		.pin_o(memory_mask_pin_o),
		.oe_o(memory_mask_pin_oe_o)
	);

	assign trk_req = (|ctl_refresh_done_i) | (|ctl_long_idle_i);

	// Datapath pins and read return
	always_comb
	begin
		dqs_oe_next = strobe_window_i;
		dqs_next = strobe_wave(strobe_window_i, 1'b0);
		dqsc_next = strobe_wave(strobe_window_i, 1'b1);
		bws_next = byte_mask_b_i;
		dinv_next = dinv_i;
		// Read data is captured every cycle; only valid slots carry meaning
		rdata_next = mem_dq_i;
		// A request drops valid in the same edge as the success flag
		rvalid_next = (state_reg == mpd_pkg::MPD_DONE && !cal_req_i)
			? rdata_en_full_i : '0;
	end

	// Sequencer: calibration, result, tracking
	always_comb
	begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		ok_next = ok_reg;
		fail_next = fail_reg;
		wlat_next = wlat_reg;
		rlat_next = rlat_reg;
		busy_next = '0;
		if (cal_req_i)
		begin
			// Held request keeps everything at reset values
			state_next = mpd_pkg::MPD_IDLE;
			cnt_next = '0;
			ok_next = 1'b0;
			fail_next = 1'b0;
			wlat_next = mpd_pkg::WLAT_RESET;
			rlat_next = mpd_pkg::RLAT_RESET;
		end
		else
		begin
			case (state_reg)
				mpd_pkg::MPD_IDLE:
				begin
					state_next = mpd_pkg::MPD_CAL;
					cnt_next = '0;
				end
				mpd_pkg::MPD_CAL:
				begin
					cnt_next = cnt_reg + 8'h01;
					if (cnt_reg == mpd_pkg::CAL_CYCLES - 8'h01)
					begin
						// Latencies fixed on the same edge as the success or failure flag
						wlat_next = mpd_pkg::WLAT_DEFAULT;
						rlat_next = mpd_pkg::RLAT_DEFAULT;
						if (cal_result_ok_i)
						begin
							state_next = mpd_pkg::MPD_DONE;
							ok_next = 1'b1;
						end
						else
						begin
							state_next = mpd_pkg::MPD_FAIL;
							fail_next = 1'b1;
						end
					end
				end
				mpd_pkg::MPD_DONE:
				begin
					if (tracking_enable_i && trk_req)
					begin
						state_next = mpd_pkg::MPD_TRACK;
						cnt_next = '0;
						busy_next = '1;
					end
				end
				mpd_pkg::MPD_TRACK:
				begin
					cnt_next = cnt_reg + 8'h01;
					busy_next = '1;
					if (cnt_reg == mpd_pkg::TRK_CYCLES - 8'h01)
					begin
						state_next = mpd_pkg::MPD_DONE;
						busy_next = '0;
					end
				end
				mpd_pkg::MPD_FAIL:
					state_next = mpd_pkg::MPD_FAIL;
				default:
					state_next = mpd_pkg::MPD_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			state_reg <= mpd_pkg::MPD_IDLE;
			cnt_reg <= '0;
			ok_reg <= 1'b0;
			fail_reg <= 1'b0;
			wlat_reg <= mpd_pkg::WLAT_RESET;
			rlat_reg <= mpd_pkg::RLAT_RESET;
			busy_reg <= '0;
			dqs_reg <= '0;
			dqsc_reg <= '0;
			dqs_oe_reg <= '0;
			bws_reg <= '1;
			dinv_reg <= '0;
			rdata_reg <= '0;
			rvalid_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			ok_reg <= ok_next;
			fail_reg <= fail_next;
			wlat_reg <= wlat_next;
			rlat_reg <= rlat_next;
			busy_reg <= busy_next;
			dqs_reg <= dqs_next;
			dqsc_reg <= dqsc_next;
			dqs_oe_reg <= dqs_oe_next;
			bws_reg <= bws_next;
			dinv_reg <= dinv_next;
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	assign cal_success_o = ok_reg;
	assign cal_fail_o = fail_reg;
	assign wlat_o = wlat_reg;
	assign rlat_o = rlat_reg;
	assign seq_busy_o = busy_reg;
	assign mem_dqs_o = dqs_reg;
	assign mem_dqs_c_o = dqsc_reg;
	assign mem_dqs_oe_o = dqs_oe_reg;
	assign mem_bws_b_o = bws_reg;
	assign mem_dinv_o = dinv_reg;
	assign rdata_o = rdata_reg;
	assign rdata_valid_o = rvalid_reg;
endmodule : mpd_port
`default_nettype wire

/* File: src/mpd_pkg.sv */
// Constants and types for the memory PHY data and calibration port
// Notes on behaviour
// - Strobe window drives both strobe pins
// - Write valid per slot enables data, mask
// - Write data sent at double data rate
// - Mask input drives mask or inversion pin
// - Byte-write-select pins follow active-low mask
// - Data inversion pins follow inversion input
// - Read data meaningful only when valid
// - Read valid one bit per slot
// - Success flag after good calibration
// - Failure flag after failed calibration
// - Calibration request resets, release restarts sequencer
// - Per-group write latency reported, 0 to 63
// - Read latency reported, 0 to 63
// - Tracking suspends read valid for TRK_CYCLES cycles, strobe enable unchanged
// - Busy held while strobe tracking runs
// - Earliest slot in least significant position
package mpd_pkg;
	localparam int unsigned RATE = 2;
	localparam int unsigned DQ_PINS = 8;
	localparam int unsigned DQ_WIDTH = DQ_PINS * 2 * RATE;
	localparam int unsigned MASK_PINS = 1;
	localparam int unsigned MASK_BUS_WIDTH = MASK_PINS * 2 * RATE;
	localparam int unsigned WDQS_GROUPS = 1;
	localparam int unsigned LAT_WIDTH = 6;
	localparam int unsigned TRK_WIDTH = 4;
	localparam int unsigned CAL_CNT_WIDTH = 8;
	localparam logic [7:0] CAL_CYCLES = 8'h40;
	localparam logic [7:0] TRK_CYCLES = 8'h10;
	localparam logic [5:0] WLAT_RESET = 6'h00;
	localparam logic [5:0] RLAT_RESET = 6'h00;
	localparam logic [5:0] RLAT_DEFAULT = 6'h04;
	localparam logic [5:0] WLAT_DEFAULT = 6'h02;
	typedef enum logic [2:0]
	{
		MPD_IDLE = 3'b000,
		MPD_CAL = 3'b001,
		MPD_DONE = 3'b010,
		MPD_FAIL = 3'b011,
		MPD_TRACK = 3'b100
	} mpd_state_t;
endpackage : mpd_pkg

/* File: src/mpd_lane.sv */
// One registered lane: slot-wide parallel word to pin level with enable
`timescale 1ns/1ps
`default_nettype none
module mpd_lane #(
	parameter int unsigned W = 8
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_b_i,
	// Parallel side, earliest slot in low bits
	input wire logic [W*2*mpd_pkg::RATE-1:0] word_i,
	input wire logic [mpd_pkg::RATE-1:0] en_i,
	// Registered pin side
	output logic [W*2*mpd_pkg::RATE-1:0] pin_o,
	output logic [mpd_pkg::RATE-1:0] oe_o
);
	logic [W*2*mpd_pkg::RATE-1:0] pin_reg, pin_next;
	logic [mpd_pkg::RATE-1:0] oe_reg, oe_next;

	always_comb
	begin
		pin_next = word_i;
		oe_next = en_i;
	end

	always_ff @(posedge clock_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			pin_reg <= '0;
			oe_reg <= '0;
		end
		else
		begin
			pin_reg <= pin_next;
			oe_reg <= oe_next;
		end
	end

	assign pin_o = pin_reg;
	assign oe_o = oe_reg;
endmodule : mpd_lane
`default_nettype wire

/* File: verif/mpd_port_monitor.sv */
// Property checker for the memory PHY data and calibration port
`timescale 1ns/1ps
`default_nettype none
module mpd_port_monitor (
	// Watched ports
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic [mpd_pkg::RATE-1:0] strobe_window_i,
	input wire logic [mpd_pkg::RATE-1:0] wdata_valid_i,
	input wire logic [mpd_pkg::DQ_WIDTH-1:0] wdata_i,
	input wire logic [mpd_pkg::MASK_BUS_WIDTH-1:0] write_mask_or_inversion_i,
	input wire logic [mpd_pkg::MASK_BUS_WIDTH-1:0] byte_mask_b_i,
	input wire logic [mpd_pkg::WDQS_GROUPS*2-1:0] dinv_i,
	input wire logic [mpd_pkg::RATE-1:0] rdata_en_full_i,
	input wire logic [mpd_pkg::RATE-1:0] rdata_valid_o,
	input wire logic cal_req_i,
	input wire logic cal_success_o,
	input wire logic cal_fail_o,
	input wire logic [mpd_pkg::LAT_WIDTH-1:0] wlat_o,
	input wire logic [mpd_pkg::LAT_WIDTH-1:0] rlat_o,
	input wire logic [mpd_pkg::TRK_WIDTH-1:0] seq_busy_o,
	input wire logic [mpd_pkg::DQ_WIDTH-1:0] mem_dq_o,
	input wire logic [mpd_pkg::RATE-1:0] mem_dq_oe_o,
	input wire logic [mpd_pkg::MASK_BUS_WIDTH-1:0] memory_mask_pin_o,
	input wire logic [mpd_pkg::RATE-1:0] memory_mask_pin_oe_o,
	input wire logic [mpd_pkg::MASK_BUS_WIDTH-1:0] mem_bws_b_o,
	input wire logic [mpd_pkg::WDQS_GROUPS*2-1:0] mem_dinv_o,
	input wire logic [2*mpd_pkg::RATE-1:0] mem_dqs_o,
	input wire logic [2*mpd_pkg::RATE-1:0] mem_dqs_c_o,
	input wire logic [mpd_pkg::RATE-1:0] mem_dqs_oe_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);
	property p_strobe;
		strobe_window_i[0] |=> mem_dqs_oe_o[0] && mem_dqs_o[1:0] == 2'h1
			&& mem_dqs_c_o[1:0] == 2'h2;
	endproperty
	a_strobe: assert property (p_strobe) else $error("strobe pins");
	property p_wdata;
		wdata_valid_i[0] |=> mem_dq_oe_o[0] && memory_mask_pin_oe_o[0]
			&& mem_dq_o[15:0] == $past(wdata_i[15:0])
			&& memory_mask_pin_o[1:0] == $past(write_mask_or_inversion_i[1:0]);
	endproperty
	a_wdata: assert property (p_wdata) else $error("write slot 0");
	property p_side;
		1'b1 |=> mem_bws_b_o == $past(byte_mask_b_i)
			&& mem_dinv_o == $past(dinv_i);
	endproperty
	a_side: assert property (p_side) else $error("bws or dinv");
	property p_rvalid;
		|rdata_valid_o |-> rdata_valid_o == $past(rdata_en_full_i)
			&& cal_success_o;
	endproperty
	a_rvalid: assert property (p_rvalid) else $error("read valid");
	property p_excl;
		!(cal_success_o && cal_fail_o);
	endproperty
	a_excl: assert property (p_excl) else $error("both flags");
	property p_req;
		cal_req_i |=> !cal_success_o && !cal_fail_o;
	endproperty
	a_req: assert property (p_req) else $error("flag in request");
	property p_lat;
		$rose(cal_success_o) |-> wlat_o == 6'h02 && rlat_o == 6'h04;
	endproperty
	a_lat: assert property (p_lat) else $error("latency");
	// A calibration request may legally cut tracking short
	property p_busy;
		disable iff (!rst_b_i || cal_req_i)
		$rose(seq_busy_o[0]) |-> seq_busy_o == 4'hf [*8];
	endproperty
	a_busy: assert property (p_busy) else $error("busy dropped");
	c_fail: cover property (cal_fail_o);
	c_busy: cover property (seq_busy_o == 4'hf);
	c_write: cover property (mem_dq_oe_o[0]);
endmodule : mpd_port_monitor
bind mpd_port mpd_port_monitor u_mon (.*);
`default_nettype wire

/* File: verif/mpd_ctl_model.sv */
// Controller stand-in that issues one write burst per go pulse
`timescale 1ns/1ps
`default_nettype none
module mpd_ctl_model (
	// Clock and trigger
	input wire logic clock_i,
	input wire logic go_i,
	input wire logic [31:0] data_i,
	// Write side toward the port
	output logic [1:0] strobe_window_o,
	output logic [1:0] wdata_valid_o,
	output logic [31:0] wdata_o
);
	logic [1:0] ph_reg = 2'h0;
	always @(posedge clock_i)
		ph_reg <= {ph_reg[0], go_i};
	// Window opens a cycle early for the preamble, closes with valid
	assign strobe_window_o = {1'b0, |ph_reg};
	assign wdata_valid_o = {1'b0, ph_reg[1]};
	// Idle data inverted so a stale word never passes for a match
	assign wdata_o = ph_reg[1] ? data_i : ~data_i;
endmodule : mpd_ctl_model
`default_nettype wire

/* File: verif/mpd_port_tb_top.sv */
// Self-checking bench for the memory PHY data and calibration port
`timescale 1ns/1ps
`default_nettype none
module mpd_port_tb_top;
	logic clock_i = 0, rst_b_i = 0, cal_req_i = 0, cal_result_ok_i = 1;
	logic tracking_enable_i = 0, go = 0, cal_success_o, cal_fail_o;
	logic [1:0] strobe_window_i, wdata_valid_i, rdata_en_full_i = 0;
	logic [1:0] dinv_i = 0, mem_dinv_o, rdata_valid_o, mem_dq_oe_o;
	logic [1:0] memory_mask_pin_oe_o, mem_dqs_oe_o;
	logic [31:0] wdata_i, rdata_o, mem_dq_o, mem_dq_i = 32'h1234abcd;
	logic [31:0] wd = 32'h5a5ac3c3;
	logic [3:0] write_mask_or_inversion_i = 0, byte_mask_b_i = 4'hf;
	logic [3:0] ctl_refresh_done_i = 0, ctl_long_idle_i = 0, seq_busy_o;
	logic [3:0] memory_mask_pin_o, mem_bws_b_o, mem_dqs_o, mem_dqs_c_o;
	logic [5:0] wlat_o, rlat_o;
	int n_mismatch = 0, num_checks = 0;
	mpd_port DUT (.*);
	mpd_ctl_model u_ctl (.clock_i(clock_i), .go_i(go), .data_i(wd),
		.strobe_window_o(strobe_window_i), .wdata_valid_o(wdata_valid_i),
		.wdata_o(wdata_i));
	always #2 clock_i = ~clock_i;
	task tick;
		@(posedge clock_i);
		#1;
	endtask : tick
	task chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	task conclude;
		if (n_mismatch == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : conclude
	task t_cal(input logic fail);
		int k;
		k = 0;
		while (cal_success_o !== 1'b1 && cal_fail_o !== 1'b1 && k < 100)
		begin
			tick;
			k++;
		end
		chk(cal_success_o, !fail);
		chk(cal_fail_o, fail);
		if (!fail)
			chk({wlat_o, rlat_o}, {6'h02, 6'h04});
	endtask : t_cal
	task t_write;
		repeat (wlat_o) tick;
		go = 1;
		tick;
		go = 0;
		tick;
		chk({mem_dqs_oe_o[0], mem_dqs_o[1:0], mem_dqs_c_o[1:0]}, 5'h16);
		chk(mem_dq_oe_o, 2'h0);
		tick;
		chk({mem_dq_oe_o, memory_mask_pin_oe_o}, 4'h5);
		chk(mem_dq_o, wd);
	endtask : t_write
	task t_mask;
		for (int i = 0; i < 4; i++)
		begin
			write_mask_or_inversion_i = 4'h1 << i;
			byte_mask_b_i = ~(4'h1 << i);
			dinv_i = i[1:0];
			tick;
			chk(memory_mask_pin_o, 4'h1 << i);
			chk(mem_bws_b_o, 4'hf ^ (4'h1 << i));
			chk(mem_dinv_o, i[1:0]);
		end
	endtask : t_mask
	task t_read;
		mem_dq_i = 32'h6b1e07f2;
		rdata_en_full_i = 2'h3;
		tick;
		rdata_en_full_i = 2'h0;
		mem_dq_i = 32'h94e1f80d;
		chk(rdata_valid_o, 2'h3);
		chk(rdata_o, 32'h6b1e07f2);
		tick;
		chk(rdata_valid_o, 2'h0);
	endtask : t_read
	task t_track;
		int k;
		ctl_long_idle_i = 4'h1;
		tick;
		tick;
		chk(seq_busy_o, 4'h0);
		ctl_long_idle_i = 4'h0;
		tracking_enable_i = 1;
		ctl_refresh_done_i = 4'h1;
		tick;
		ctl_refresh_done_i = 4'h0;
		k = 0;
		while (seq_busy_o === 4'hf && k < 40)
		begin
			k++;
			tick;
		end
		chk(k, 16);
	endtask : t_track
	task t_fail;
		cal_result_ok_i = 0;
		cal_req_i = 1;
		tick;
		chk({cal_success_o, cal_fail_o}, 2'h0);
		cal_req_i = 0;
		t_cal(1'b1);
		repeat (4) tick;
		chk(cal_fail_o, 1'b1);
	endtask : t_fail
	initial
	begin
		repeat (10) @(posedge clock_i);
		#1;
		rst_b_i = 1;
		t_cal(1'b0);
		t_write;
		t_mask;
		t_read;
		t_track;
		t_fail;
		conclude;
	end
	initial
	begin
		#5000;
		n_mismatch++;
		conclude;
	end
endmodule : mpd_port_tb_top
`default_nettype wire
